// File: shared/pbc_pkg.sv
// constants and types shared by the basic control register block
package pbc_pkg;
    // system clock and soft reset timing
    localparam int CLK_PERIOD_NS     = 40;
    localparam int SOFT_RESET_NS     = 25000;
    localparam int SOFT_RESET_CYCLES =
        (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W           = 10;

    // register map and layout
    localparam logic [4:0]  REG_BPC_ADDR  = 5'h00;
    localparam logic [15:0] CTRL_RESET    = 16'h3000;
    localparam logic [15:0] CTRL_RW_MASK  = 16'h7D80;
    localparam logic [15:0] CTRL_RD_MASK  = 16'hFF80;
    localparam int BIT_SOFT_RESET    = 15;
    localparam int BIT_LOOPBACK      = 14;
    localparam int BIT_SPEED_LOW     = 13;
    localparam int BIT_AUTONEG_EN    = 12;
    localparam int BIT_POWER_DOWN    = 11;
    localparam int BIT_ISOLATE       = 10;
    localparam int BIT_AUTONEG_RST   = 9;
    localparam int BIT_DUPLEX        = 8;
    localparam int BIT_COLL_TEST     = 7;

    // management frame fields
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [4:0] ADDR_LAST = 5'h09;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    localparam logic [4:0] OP_LAST   = 5'h01;
    localparam logic [4:0] TA_LAST   = 5'h01;

    // cycles after reset release before straps are trusted;
    // the synchroniser level is valid only after four edges
    localparam logic [2:0] STRAP_SETTLE = 3'h4;

    // width of the pin synchroniser bank
    localparam int SYNC_W = 10;

    typedef enum logic [2:0] {
        PBC_PRE,
        PBC_START,
        PBC_OP,
        PBC_ADDR,
        PBC_TA,
        PBC_DATA
    } pbc_mgmt_state_t;
endpackage

// File: src/pbc_sync.sv
// three-flop pin synchroniser bank with two-stage agreement
`timescale 1ns/1ps
module pbc_sync import pbc_pkg::*; #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // pins in, filtered levels out
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } pbc_sync_t;

    pbc_sync_t s_q;
    pbc_sync_t s_d;
    logic [WIDTH-1:0] agree;

    always_comb begin
        s_d    = s_q;
        s_d.s1 = din;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        agree  = ~(s_q.s2 ^ s_q.s3);
        // a change counts only once stages two and three agree
        s_d.lvl = (agree & s_q.s2) | (~agree & s_q.lvl);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.lvl;
endmodule

// File: src/pbc_reset_timer.sv
// soft reset interval timer
`timescale 1ns/1ps
module pbc_reset_timer import pbc_pkg::*; (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // start pulse in, busy level and done pulse out
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    typedef struct packed {
        logic               busy;
        logic               done;
        logic [TIMER_W-1:0] cnt;
    } pbc_timer_t;

    localparam logic [TIMER_W-1:0] LAST =
        TIMER_W'(SOFT_RESET_CYCLES - 1);

    pbc_timer_t s_q;
    pbc_timer_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (s_q.busy) begin
            if (s_q.cnt == LAST) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end else if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt  = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule

// File: src/pbc_control.sv
// basic control register with its serial management slave
`timescale 1ns/1ps
module pbc_control import pbc_pkg::*; (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // management pins
    input  wire logic       mdc,
    input  wire logic       mdioIn,
    output logic            mdioOut,
    output logic            mdioOe,
    // strap and control pins
    input  wire logic [4:0] phyAddr,
    input  wire logic       autonegStrapPin,
    input  wire logic       powerDownPin,
    input  wire logic       txEnPin,
    // autoneg engine and line side, same clock
    input  wire logic       autonegStarted,
    input  wire logic       anSpeed100,
    input  wire logic       anFullDuplex,
    input  wire logic       lineCollision,
    // strobes and mode outputs
    output logic            softResetActive,
    output logic            softResetStrobe,
    output logic            autonegRestartStrobe,
    output logic            autonegEnable,
    output logic            speed100,
    output logic            fullDuplex,
    output logic            loopbackEnable,
    output logic            powerDownActive,
    output logic            isolateMii,
    // pin enables and collision
    output logic            lineTxOe,
    output logic            ledOe,
    output logic            miiOutOe,
    output logic            txAccept,
    output logic            collisionOut
);
    typedef struct packed {
        pbc_mgmt_state_t st;
        logic [4:0]      cnt;
        logic [15:0]     sh;
        logic            opRead;
        logic            sel;
        logic            hit;
        logic            mdcLast;
        logic            mdioOut;
        logic            mdioOe;
        logic [15:0]     ctrl;
        logic            strapPend;
        logic [2:0]      strapWait;
        logic            rstStrobe;
        logic            ranStrobe;
        logic            autoneg_enable;
        logic            spd;
        logic            fdx;
        logic            loopback_enable;
        logic            pd;
        logic            iso;
        logic            lineOe;
        logic            ledOe;
        logic            miiOe;
        logic            txOk;
        logic            col;
    } pbc_state_t;

    pbc_state_t s_q;
    pbc_state_t s_d;

    logic [SYNC_W-1:0] pinSync;
    logic [4:0]        phyAddrF;
    logic              txEnF;
    logic              pwrF;
    logic              strapF;
    logic              mdioF;
    logic              mdcF;
    logic              timerBusy;
    logic              timerDone;

    pbc_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst    (rst),
        .din    ({phyAddr, txEnPin, powerDownPin, autonegStrapPin,
                  mdioIn, mdc}),
        .dout   (pinSync)
    );

    assign {phyAddrF, txEnF, pwrF, strapF, mdioF, mdcF} = pinSync;

    pbc_reset_timer u_timer (
        .clk_sys(clk_sys),
        .rst    (rst),
        .start  (s_q.rstStrobe),
        .busy   (timerBusy),
        .done   (timerDone)
    );

    always_comb begin
        logic        rise;
        logic        wr;
        logic [15:0] wd;
        logic [15:0] rd;
        logic [9:0]  addr;
        rise = mdcF & ~s_q.mdcLast;
        wr   = 1'b0;
        wd   = {s_q.sh[14:0], mdioF};
        addr = {s_q.sh[8:0], mdioF};
        rd   = s_q.ctrl & CTRL_RD_MASK;

        s_d           = s_q;
        s_d.mdcLast   = mdcF;
        s_d.rstStrobe = 1'b0;
        s_d.ranStrobe = 1'b0;

        if (rise) begin
            case (s_q.st)
                PBC_PRE: begin
                    if (!mdioF) begin
                        s_d.st = PBC_START;
                    end
                end
                PBC_START: begin
                    s_d.cnt = '0;
                    s_d.st  = mdioF ? PBC_OP : PBC_PRE;
                end
                PBC_OP: begin
                    s_d.sh  = wd;
                    s_d.cnt = s_q.cnt + 1'b1;
                    if (s_q.cnt == OP_LAST) begin
                        s_d.cnt    = '0;
                        s_d.opRead = (wd[1:0] == OP_READ);
                        if (wd[1:0] == OP_READ || wd[1:0] == OP_WRITE) begin
                            s_d.st = PBC_ADDR;
                        end else begin
                            s_d.st = PBC_PRE;
                        end
                    end
                end
                PBC_ADDR: begin
                    s_d.sh  = wd;
                    s_d.cnt = s_q.cnt + 1'b1;
                    if (s_q.cnt == ADDR_LAST) begin
                        s_d.cnt = '0;
                        s_d.st  = PBC_TA;
                        s_d.sel = (addr[9:5] == phyAddrF);
                        s_d.hit = (addr[4:0] == REG_BPC_ADDR);
                        if (s_q.opRead && addr[9:5] == phyAddrF) begin
                            s_d.mdioOe  = 1'b1;
                            s_d.mdioOut = 1'b0;
                        end
                    end
                end
                PBC_TA: begin
                    s_d.cnt = s_q.cnt + 1'b1;
                    if (s_q.cnt == TA_LAST) begin
                        s_d.cnt = '0;
                        s_d.st  = PBC_DATA;
                        if (s_q.opRead) begin
                            // unmapped registers read as zero
                            s_d.sh      = s_q.hit ? {rd[14:0], 1'b0} : '0;
                            s_d.mdioOut = s_q.hit & rd[15];
                        end
                    end
                end
                PBC_DATA: begin
                    s_d.cnt = s_q.cnt + 1'b1;
                    if (s_q.opRead) begin
                        s_d.mdioOut = s_q.sh[15];
                        s_d.sh      = {s_q.sh[14:0], 1'b0};
                    end else begin
                        s_d.sh = wd;
                    end
                    if (s_q.cnt == DATA_LAST) begin
                        s_d.st      = PBC_PRE;
                        s_d.mdioOe  = 1'b0;
                        s_d.mdioOut = 1'b0;
                        wr = ~s_q.opRead & s_q.sel & s_q.hit;
                    end
                end
                default: begin
                    s_d.st = PBC_PRE;
                end
            endcase
        end

        if (s_q.strapPend) begin
            if (s_q.strapWait == STRAP_SETTLE) begin
                s_d.strapPend            = 1'b0;
                s_d.ctrl[BIT_AUTONEG_EN] = strapF;
            end else begin
                s_d.strapWait = s_q.strapWait + 1'b1;
            end
        end

        if (autonegStarted && s_q.ctrl[BIT_AUTONEG_RST]) begin
            s_d.ctrl[BIT_AUTONEG_RST] = 1'b0;
        end

        // writes are ignored while a soft reset runs
        if (wr && !s_q.ctrl[BIT_SOFT_RESET]) begin
            s_d.ctrl = (s_d.ctrl & ~CTRL_RW_MASK) | (wd & CTRL_RW_MASK);
            if (wd[BIT_SOFT_RESET]) begin
                s_d.ctrl[BIT_SOFT_RESET] = 1'b1;
                s_d.rstStrobe            = 1'b1;
            end
            if (wd[BIT_AUTONEG_RST] && wd[BIT_AUTONEG_EN]) begin
                s_d.ctrl[BIT_AUTONEG_RST] = 1'b1;
                s_d.ranStrobe             = 1'b1;
            end
        end

        if (timerDone) begin
            s_d.ctrl                 = CTRL_RESET;
            s_d.ctrl[BIT_AUTONEG_EN] = strapF;
        end

        s_d.autoneg_enable = s_d.ctrl[BIT_AUTONEG_EN];
        s_d.spd  = s_d.autoneg_enable ? anSpeed100 : s_d.ctrl[BIT_SPEED_LOW];
        s_d.fdx  = s_d.autoneg_enable ? anFullDuplex : s_d.ctrl[BIT_DUPLEX];
        s_d.loopback_enable = s_d.ctrl[BIT_LOOPBACK];
        s_d.pd   = s_d.ctrl[BIT_POWER_DOWN] | pwrF;
        s_d.iso  = s_d.ctrl[BIT_ISOLATE] | s_d.pd;
        s_d.lineOe = ~(s_d.pd | s_d.loopback_enable);
        s_d.ledOe  = ~s_d.pd;
        s_d.miiOe  = ~s_d.iso;
        s_d.txOk   = ~s_d.iso;
        if (s_d.iso) begin
            s_d.col = 1'b0;
        end else if (s_d.ctrl[BIT_COLL_TEST]) begin
            s_d.col = txEnF;
        end else begin
            s_d.col = lineCollision;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q           <= '0;
            s_q.ctrl      <= CTRL_RESET;
            s_q.strapPend <= 1'b1;
            s_q.autoneg_enable      <= 1'b1;
            s_q.lineOe    <= 1'b1;
            s_q.ledOe     <= 1'b1;
            s_q.miiOe     <= 1'b1;
            s_q.txOk      <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign softResetStrobe      = s_q.rstStrobe;
    assign autonegRestartStrobe = s_q.ranStrobe;
    assign softResetActive      = s_q.ctrl[BIT_SOFT_RESET];
    assign mdioOut              = s_q.mdioOut;
    assign mdioOe               = s_q.mdioOe;
    assign autonegEnable        = s_q.autoneg_enable;
    assign speed100             = s_q.spd;
    assign fullDuplex           = s_q.fdx;
    assign loopbackEnable       = s_q.loopback_enable;
    assign powerDownActive      = s_q.pd;
    assign isolateMii           = s_q.iso;
    assign lineTxOe             = s_q.lineOe;
    assign ledOe                = s_q.ledOe;
    assign miiOutOe             = s_q.miiOe;
    assign txAccept             = s_q.txOk;
    assign collisionOut         = s_q.col;
endmodule

// File: sim/pbc_control_chk.sv
// assertion checker for the basic control register outputs
`timescale 1ns/1ps
module pbc_control_chk import pbc_pkg::*; (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // pins seen by the block
    input  wire logic powerDownPin,
    input  wire logic anSpeed100,
    input  wire logic anFullDuplex,
    // mode and strobe outputs
    input  wire logic softResetActive,
    input  wire logic softResetStrobe,
    input  wire logic autonegRestartStrobe,
    input  wire logic autonegEnable,
    input  wire logic speed100,
    input  wire logic fullDuplex,
    input  wire logic loopbackEnable,
    input  wire logic powerDownActive,
    input  wire logic isolateMii,
    // pin enables and collision
    input  wire logic lineTxOe,
    input  wire logic ledOe,
    input  wire logic miiOutOe,
    input  wire logic txAccept,
    input  wire logic collisionOut
);
    localparam int SR_MAX = SOFT_RESET_CYCLES + 8;
    logic [15:0] srCnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // length of the current soft reset interval
    always_ff @(posedge clk_sys) begin
        if (rst || !softResetActive) begin
            srCnt <= 16'h0000;
        end else begin
            srCnt <= srCnt + 16'h0001;
        end
    end

    sequence srBegin;
        $rose(softResetActive);
    endsequence
    sequence srPulse;
        ##[0:2] softResetStrobe ##1 !softResetStrobe;
    endsequence

    a_reset_pulse: assert property (srBegin |-> srPulse)
        else $error("soft reset strobe missing or too long");
    a_reset_length: assert property (
        $fell(softResetActive) |-> srCnt >= SOFT_RESET_CYCLES)
        else $error("soft reset interval too short");
    a_reset_bounded: assert property (
        softResetActive |-> srCnt < SR_MAX)
        else $error("soft reset bit never clears");
    a_restart_pulse: assert property (
        autonegRestartStrobe |=> !autonegRestartStrobe)
        else $error("restart strobe longer than one cycle");
    a_restart_needs_an: assert property (
        $rose(autonegRestartStrobe) |-> ##1 autonegEnable)
        else $error("restart without autoneg enabled");
    a_pd_outputs: assert property (
        powerDownActive [*2] |-> !ledOe && !lineTxOe && isolateMii)
        else $error("power down leaves outputs driven");
    a_pd_pin: assert property (
        powerDownPin [*8] |-> powerDownActive)
        else $error("power down pin ignored");
    a_iso_outputs: assert property (
        isolateMii [*3] |-> !miiOutOe && !txAccept && !collisionOut)
        else $error("isolated port still drives the MII");
    a_loop_tx_off: assert property (
        loopbackEnable [*2] |-> !lineTxOe)
        else $error("line transmitter driven in loopback");
    a_speed_follow: assert property (
        (autonegEnable && $stable(anSpeed100)) [*3] |-> speed100 == anSpeed100)
        else $error("speed does not follow autoneg");
    a_duplex_follow: assert property (
        (autonegEnable && $stable(anFullDuplex)) [*3]
            |-> fullDuplex == anFullDuplex)
        else $error("duplex does not follow autoneg");
endmodule

bind pbc_control pbc_control_chk i_chk (
    .clk_sys, .rst, .powerDownPin, .anSpeed100, .anFullDuplex,
    .softResetActive, .softResetStrobe, .autonegRestartStrobe,
    .autonegEnable, .speed100, .fullDuplex, .loopbackEnable,
    .powerDownActive, .isolateMii, .lineTxOe, .ledOe, .miiOutOe,
    .txAccept, .collisionOut
);

// File: sim/pbc_mgmt_master.sv
// management station model that clocks frames over mdc and mdio
`timescale 1ns/1ps
module pbc_mgmt_master import pbc_pkg::*; #(
    parameter int HALF = 10
) (
    // clock
    input  wire logic clk_sys,
    // management pins
    output logic      mdc,
    output logic      mdioIn,
    input  wire logic mdioOut,
    input  wire logic mdioOe
);
    logic mOut = 1'b1;
    logic mOe  = 1'b0;
    logic seen;

    // line has a pull-up, so a released line reads 1
    assign mdioIn = mdioOe ? mdioOut : (mOe ? mOut : 1'b1);
    initial mdc = 1'b0;

    // one bit: drive after the fall, sample just before the rise
    task automatic shift(input logic b, input logic drv);
        mdc = 1'b0;
        mOe = drv;
        mOut = b;
        repeat (HALF) @(negedge clk_sys);
        seen = mdioIn;
        mdc = 1'b1;
        repeat (HALF) @(negedge clk_sys);
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [15:0] hdr;
        logic        wrOp;
        hdr = {2'b11, 2'b01, op, pa, ra};
        wrOp = (op == OP_WRITE);
        @(negedge clk_sys);
        for (int i = 15; i >= 0; i--) shift(hdr[i], 1'b1);
        shift(1'b1, wrOp);
        shift(1'b0, wrOp);
        for (int i = 15; i >= 0; i--) begin
            shift(wd[i], wrOp);
            rd[i] = seen;
        end
        // idle bit with the line released
        shift(1'b1, 1'b0);
    endtask
endmodule

// File: sim/phy_basic_control_register_bench.sv
// self-checking bench for the basic control register
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    failures++; $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
    end end
module phy_basic_control_register_bench import pbc_pkg::*;;
    localparam logic [4:0] MY_ADDR = 5'h05;
    logic clk_sys = 1'b0, rst = 1'b1, mdc, mdioIn, mdioOut, mdioOe;
    logic [4:0] phyAddr = MY_ADDR;
    logic autonegStrapPin = 1'b1, powerDownPin = 1'b0, txEnPin = 1'b0;
    logic autonegStarted = 1'b0, anSpeed100 = 1'b1, anFullDuplex = 1'b0;
    logic lineCollision = 1'b0;
    logic softResetActive, softResetStrobe, autonegRestartStrobe;
    logic autonegEnable, speed100, fullDuplex, loopbackEnable;
    logic powerDownActive, isolateMii, lineTxOe, ledOe, miiOutOe;
    logic txAccept, collisionOut;
    int   failures = 0, checks = 0, anRestarts = 0;

    pbc_control i_dut (
        .clk_sys, .rst, .mdc, .mdioIn, .mdioOut, .mdioOe, .phyAddr,
        .autonegStrapPin, .powerDownPin, .txEnPin, .autonegStarted,
        .anSpeed100, .anFullDuplex, .lineCollision, .softResetActive,
        .softResetStrobe, .autonegRestartStrobe, .autonegEnable,
        .speed100, .fullDuplex, .loopbackEnable, .powerDownActive,
        .isolateMii, .lineTxOe, .ledOe, .miiOutOe, .txAccept, .collisionOut
    );
    pbc_mgmt_master #(.HALF(10)) i_mac (
        .clk_sys, .mdc, .mdioIn, .mdioOut, .mdioOe
    );

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // negotiation engine reports start one cycle after each restart
    always @(negedge clk_sys) autonegStarted <= autonegRestartStrobe;
    // counted away from the launching edge to avoid a race
    always @(negedge clk_sys) begin
        if (autonegRestartStrobe === 1'b1) anRestarts++;
    end

    task automatic settle();
        repeat (8) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] junk;
        i_mac.frame(OP_WRITE, MY_ADDR, ra, d, junk);
        settle();
    endtask
    task automatic rd(input logic [4:0] ra, output logic [15:0] d);
        i_mac.frame(OP_READ, MY_ADDR, ra, 16'h0000, d);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        conclude();
    end

    initial begin
        logic [15:0] v;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        settle();
        rd(5'h00, v);
        `CHK("ctrl", 16'h3000, v);
        `CHK("speed", 1'b1, speed100);
        `CHK("duplex", 1'b0, fullDuplex);
        `CHK("lineOe", 1'b1, lineTxOe);
        // with autoneg on, speed and duplex follow the engine
        anSpeed100 = 1'b0;
        anFullDuplex = 1'b1;
        settle();
        `CHK("anSpeed", 1'b0, speed100);
        `CHK("anDuplex", 1'b1, fullDuplex);
        anSpeed100 = 1'b1;
        wr(5'h00, 16'h3200);
        `CHK("restarts", 1, anRestarts);
        rd(5'h00, v);
        `CHK("ctrl", 16'h3000, v);
        wr(5'h00, 16'h0200);
        anSpeed100 = 1'b0;
        anFullDuplex = 1'b0;
        `CHK("restarts", 1, anRestarts);
        // loopback tried only with autoneg off
        wr(5'h00, 16'h6DFF);
        rd(5'h00, v);
        `CHK("ctrl", 16'h6D80, v);
        `CHK("loop", 1'b1, loopbackEnable);
        `CHK("speed", 1'b1, speed100);
        `CHK("duplex", 1'b1, fullDuplex);
        `CHK("pd", 1'b1, powerDownActive);
        `CHK("lineOe", 1'b0, lineTxOe);
        `CHK("ledOe", 1'b0, ledOe);
        `CHK("iso", 1'b1, isolateMii);
        `CHK("miiOe", 1'b0, miiOutOe);
        `CHK("txAcc", 1'b0, txAccept);
        // isolate alone, without power down
        wr(5'h00, 16'h0400);
        `CHK("isoOnly", 1'b1, isolateMii);
        `CHK("pdOff", 1'b0, powerDownActive);
        `CHK("ledOn", 1'b1, ledOe);
        `CHK("miiOeIso", 1'b0, miiOutOe);
        `CHK("txAccIso", 1'b0, txAccept);
        wr(5'h00, 16'h2180);
        txEnPin = 1'b1;
        settle();
        `CHK("col", 1'b1, collisionOut);
        txEnPin = 1'b0;
        settle();
        `CHK("col", 1'b0, collisionOut);
        powerDownPin = 1'b1;
        settle();
        `CHK("pd", 1'b1, powerDownActive);
        `CHK("ledOe", 1'b0, ledOe);
        rd(5'h00, v);
        `CHK("ctrl", 16'h2180, v);
        powerDownPin = 1'b0;
        wr(5'h01, 16'hFFFF);
        rd(5'h01, v);
        `CHK("unmapped", 16'h0000, v);
        i_mac.frame(OP_READ, 5'h06, 5'h00, 16'h0000, v);
        `CHK("otherAddr", 16'hFFFF, v);
        autonegStrapPin = 1'b0;
        wr(5'h00, 16'h8000);
        `CHK("srActive", 1'b1, softResetActive);
        rd(5'h00, v);
        `CHK("rstBit", 1'b1, v[15]);
        for (int n = 0; n < 1000 && softResetActive !== 1'b0; n++) begin
            @(negedge clk_sys);
        end
        `CHK("srActive", 1'b0, softResetActive);
        settle();
        rd(5'h00, v);
        `CHK("ctrl", 16'h2000, v);
        `CHK("autoneg_enable", 1'b0, autonegEnable);
        // collision test off: line collision passes through
        lineCollision = 1'b1;
        settle();
        `CHK("colLine", 1'b1, collisionOut);
        lineCollision = 1'b0;
        conclude();
    end
endmodule
